// *** hdl/spi_engine_pkg.sv ***
// Purpose: Shared constants and types for the byte-wide serial master/slave engine.
// Assumes: 100 MHz system clock; one byte per transfer.
// Notes:   Half-bit counter runs 0..15; even counts are leading clock edges.

package spi_engine_pkg;

	// ---------------------------------------------------------------
	// Widths and depths
	// ---------------------------------------------------------------
	localparam int DATA_W     = 8;
	localparam int FIFO_DEPTH = 4;
	localparam int HALF_W     = 4;
	localparam int DIV_W      = 8;
	localparam int SEL_W      = 3;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int EN_TO_CLK_SYS = 2;   // System clocks from enable to first block clock

	// ---------------------------------------------------------------
	// Half-bit positions inside one byte
	// ---------------------------------------------------------------
	localparam logic [HALF_W-1:0] HALF_FIRST  = 4'h0;
	localparam logic [HALF_W-1:0] HALF_LAST   = 4'hf;
	localparam logic [HALF_W-1:0] RX_HALF_P0  = 4'he;  // Eighth leading edge
	localparam logic [HALF_W-1:0] RX_HALF_P1  = 4'hf;  // Eighth trailing edge
	localparam logic [HALF_W-1:0] OVR_HALF_P0 = 4'hd;
	localparam logic [HALF_W-1:0] OVR_HALF_P1 = 4'he;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [DATA_W-1:0] BYTE_RST  = 8'h00;
	localparam logic [DIV_W-1:0]  DIV_RST   = 8'h00;
	localparam logic              MISO_IDLE = 1'b1;

	typedef enum logic [2:0] {
		ST_OFF  = 3'b001,
		ST_IDLE = 3'b010,
		ST_XFER = 3'b100
	} xfer_state_e;

endpackage

// *** hdl/spi_master_slave_engine.sv ***
// Purpose: Serial master/slave engine with transmit FIFO, buffers and status flags.
// Assumes: Pin inputs are asynchronous and always pass two flip-flops.
// Notes:   Control bits are plain ports; status read/clear via strobes.
// Functional notes
// - Phase 0: sample leading, change trailing.
// - Phase 1: change leading, sample trailing.
// - Polarity sets serial clock idle level.
// - Master shows first shifter bit, clock idle.
// - Master clock from eight-tap divider, resynced.
// - Disable holds reset; enable starts clocking.
// - Master disable: pins idle, status reset.
// - Master write loads shifter, starts, re-empties.
// - Queued byte follows back-to-back at byte end.
// - Transmit-empty sets on enable, triggers transfer.
// - No empty interrupt until first shifter load.
// - Receive-full sets on eighth bit, read clears.
// - Complete: half bit later in phase 0.
// - Overrun sets half bit before receive-full.
// - Slave data output idles at one.
// - Data output driven whenever out of reset, also when disabled or deselected; aux tristated in slave.
// - Deselect resets slave, ignores clock and data.
// - Select from pin or firmware bit.
// - Slave loads shifter when idle and empty.
// - Phase 0 slave busy from select fall.
// - Phase 1 slave busy from first leading edge.
// - Divider codes 0..7 give /2../256.
// - Bit order: 0 MSb first, 1 LSb first.
// - Interrupt source: empty or complete.
// - Control read clears complete flag.

`timescale 1ns/10ps

module spi_tx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             ref_clk_i,   // System clock
	input  wire logic             rst_i,       // Async reset, high
	input  wire logic             in_valid_i,  // Write request
	output logic                  in_ready_o,  // Room available
	input  wire logic [WIDTH-1:0] in_data_i,   // Write data
	output logic                  out_valid_o, // Word available
	input  wire logic             out_ready_i, // Consumer takes word
	output logic      [WIDTH-1:0] out_data_o   // Head word
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_r;
	logic [PW-1:0]    rd_ptr_r;
	logic [CW-1:0]    cnt_r;
	logic [CW-1:0]    cnt_nxt;
	logic             push;
	logic             pop;

	assign push       = in_valid_i & in_ready_o;
	assign pop        = out_valid_o & out_ready_i;
	assign out_data_o = mem[rd_ptr_r];

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == LAST_PTR) ? '0 : p + 1'b1;
	endfunction

	always_comb begin
		cnt_nxt = cnt_r;
		if (push & ~pop)
			cnt_nxt = cnt_r + 1'b1;
		else if (pop & ~push)
			cnt_nxt = cnt_r - 1'b1;
	end

	always_ff @(posedge ref_clk_i) begin
		if (push)
			mem[wr_ptr_r] <= in_data_i;
	end

	// Flags are registered so the ready seen by the source is glitch free
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_r    <= '0;
			rd_ptr_r    <= '0;
			cnt_r       <= '0;
			in_ready_o  <= 1'b0;
			out_valid_o <= 1'b0;
		end else begin
			if (push)
				wr_ptr_r <= ptr_inc(wr_ptr_r);
			if (pop)
				rd_ptr_r <= ptr_inc(rd_ptr_r);
			cnt_r       <= cnt_nxt;
			in_ready_o  <= (cnt_nxt != FULL_CNT);
			out_valid_o <= (cnt_nxt != '0);
		end
	end
endmodule

module spi_master_slave_engine
	import spi_engine_pkg::*;
(
	input  wire logic              ref_clk_i,    // 100 MHz system clock
	input  wire logic              rst_i,        // Async reset, high
	input  wire logic              enable_i,     // Block enable
	input  wire logic              slave_i,      // 1 = slave role
	input  wire logic              cpha_i,       // Clock phase
	input  wire logic              cpol_i,       // Clock polarity
	input  wire logic              lsb_first_i,  // Bit order
	input  wire logic [SEL_W-1:0]  clk_sel_i,    // Master divider tap
	input  wire logic              int_sel_i,    // Interrupt source
	input  wire logic              ss_en_n_i,    // 0 = firmware select
	input  wire logic              ss_fw_n_i,    // Firmware select level
	input  wire logic              ss_pin_n_i,   // Select pin, async
	input  wire logic              sclk_i,       // Slave clock pin, async
	input  wire logic              sdi_i,        // Serial data in pin, async
	input  wire logic              tx_valid_i,   // Transmit byte strobe
	input  wire logic [DATA_W-1:0] tx_data_i,    // Transmit byte
	output logic                   tx_ready_o,   // FIFO has room
	input  wire logic              rx_rd_i,      // Receive buffer read strobe
	input  wire logic              cr_rd_i,      // Control/status read strobe
	output logic      [DATA_W-1:0] rx_data_o,    // Receive buffer
	output logic                   tx_empty_o,   // Transmit empty flag
	output logic                   rx_full_o,    // Receive full flag
	output logic                   complete_o,   // Transfer complete flag
	output logic                   overrun_o,    // Overrun flag
	output logic                   irq_o,        // Interrupt level
	output logic                   sdo_o,        // Primary data out
	output logic                   sdo_oe_n_o,   // Primary enable, low drives
	output logic                   aux_o,        // Master clock out
	output logic                   aux_oe_n_o    // Aux enable, low drives
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] sclk_s_r;
	logic [1:0] sdi_s_r;
	logic [1:0] ss_s_r;
	logic       sclk_d_r;
	logic       sel_d_r;
	logic       ss_n;
	logic       selected;
	logic       master_on;
	logic       s_edge;
	logic       s_lead;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_s_r <= '0;
			sdi_s_r  <= '0;
			ss_s_r   <= 2'b11;
			sclk_d_r <= 1'b0;
			sel_d_r  <= 1'b0;
		end else begin
			sclk_s_r <= {sclk_s_r[0], sclk_i};
			sdi_s_r  <= {sdi_s_r[0], sdi_i};
			ss_s_r   <= {ss_s_r[0], ss_pin_n_i};
			sclk_d_r <= sclk_s_r[1];
			sel_d_r  <= selected;
		end
	end

	assign ss_n      = ss_en_n_i ? ss_s_r[1] : ss_fw_n_i;
	assign selected  = enable_i & slave_i & ~ss_n;
	assign master_on = enable_i & ~slave_i;
	assign s_edge    = sclk_s_r[1] ^ sclk_d_r;
	assign s_lead    = s_edge & (sclk_s_r[1] ^ cpol_i);

	// ---------------------------------------------------------------
	// Master clock divider
	// ---------------------------------------------------------------
	// The tap is resampled twice so the block clock is a clean one-cycle tick.
	logic             en_d_r;
	logic [DIV_W-1:0] div_r;
	logic             tap_r;
	logic             tap_d_r;
	logic             m_tick;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_d_r  <= 1'b0;
			div_r   <= DIV_RST;
			tap_r   <= 1'b0;
			tap_d_r <= 1'b0;
		end else begin
			en_d_r <= master_on;
			if (en_d_r)
				div_r <= div_r + 1'b1;
			else
				div_r <= DIV_RST;
			tap_r   <= en_d_r & div_r[clk_sel_i];
			tap_d_r <= tap_r;
		end
	end

	assign m_tick = tap_r & ~tap_d_r;

	// ---------------------------------------------------------------
	// Transfer sequencing
	// ---------------------------------------------------------------
	xfer_state_e       st_r;
	xfer_state_e       st_nxt;
	logic [HALF_W-1:0] hc_r;
	logic [DATA_W-1:0] txbuf_r;
	logic [DATA_W-1:0] sh_r;
	logic [DATA_W-1:0] sh_nxt;
	logic [DATA_W-1:0] rx_sh_r;
	logic [DATA_W-1:0] rx_byte;
	logic              txbuf_full_r;
	logic              txbuf_full_nxt;
	logic              sh_empty_r;
	logic              tick;
	logic              lead;
	logic              load;
	logic              shift_ev;
	logic              samp_ev;
	logic              rx_load;
	logic              byte_end;
	logic              ovr_pt;
	logic              fill;
	logic              fifo_valid;
	logic [DATA_W-1:0] fifo_data;

	assign tick = slave_i ? (selected & s_edge) : (m_tick & (st_r == ST_XFER));
	assign lead = slave_i ? s_lead : ~hc_r[0];
	assign byte_end = tick & (hc_r == HALF_LAST);

	// Master: start from idle or chain at byte end; slave: only while not busy
	always_comb begin
		if (slave_i)
			load = (st_r == ST_IDLE) & sh_empty_r & txbuf_full_r;
		else
			load = txbuf_full_r & ((st_r == ST_IDLE) |
				((st_r == ST_XFER) & byte_end));
	end

	assign shift_ev = tick & (cpha_i ? (lead & (hc_r != HALF_FIRST))
		: (~lead & (hc_r != HALF_LAST)));
	assign samp_ev = tick & (cpha_i ? ~lead : lead);
	assign rx_load = samp_ev & (hc_r == (cpha_i ? RX_HALF_P1 : RX_HALF_P0));
	assign ovr_pt  = tick & (hc_r == (cpha_i ? OVR_HALF_P1 : OVR_HALF_P0));
	assign rx_byte = lsb_first_i ? {sdi_s_r[1], rx_sh_r[DATA_W-1:1]}
		: {rx_sh_r[DATA_W-2:0], sdi_s_r[1]};

	function automatic logic out_bit(input logic [DATA_W-1:0] v, input logic lsb);
		out_bit = lsb ? v[0] : v[DATA_W-1];
	endfunction

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_OFF:
				st_nxt = ST_IDLE;
			ST_IDLE:
				if (!slave_i && load)
					st_nxt = ST_XFER;
				else if (slave_i && selected && (s_lead ||
					(!cpha_i && !sel_d_r)))
					st_nxt = ST_XFER;
			ST_XFER:
				if (!slave_i && byte_end && !load)
					st_nxt = ST_IDLE;
				else if (slave_i && (rx_load || !selected))
					st_nxt = ST_IDLE;
			default:
				st_nxt = ST_OFF;
		endcase
		if (!enable_i)
			st_nxt = ST_OFF;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= ST_OFF;
			hc_r <= HALF_FIRST;
		end else begin
			st_r <= st_nxt;
			if (!enable_i || (slave_i && !selected))
				hc_r <= HALF_FIRST;
			else if (!slave_i && st_r == ST_IDLE)
				hc_r <= HALF_FIRST;
			else if (tick)
				hc_r <= hc_r + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Data registers: kept across disable
	// ---------------------------------------------------------------
	always_comb begin
		sh_nxt = sh_r;
		if (load)
			sh_nxt = txbuf_r;
		else if (shift_ev)
			sh_nxt = lsb_first_i ? {1'b0, sh_r[DATA_W-1:1]} : {sh_r[DATA_W-2:0], 1'b0};
	end

	assign fill = enable_i & fifo_valid & (~txbuf_full_r | load);
	assign txbuf_full_nxt = enable_i & (fill | (txbuf_full_r & ~load));

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			txbuf_r   <= BYTE_RST;
			sh_r      <= BYTE_RST;
			rx_sh_r   <= BYTE_RST;
			rx_data_o <= BYTE_RST;
		end else begin
			if (fill)
				txbuf_r <= fifo_data;
			sh_r <= sh_nxt;
			if (samp_ev)
				rx_sh_r <= rx_byte;
			if (rx_load)
				rx_data_o <= rx_byte;
		end
	end

	// ---------------------------------------------------------------
	// Status flags; hardware set wins over a same-cycle clear, except overrun, which a same-cycle receive read blocks
	// ---------------------------------------------------------------
	logic arm_r;
	logic arm_nxt;
	logic cmp_nxt;
	logic emp_nxt;

	assign arm_nxt = enable_i & (arm_r | load);
	assign cmp_nxt = enable_i & (byte_end | (complete_o & ~cr_rd_i));
	assign emp_nxt = enable_i & ~txbuf_full_nxt;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			txbuf_full_r <= 1'b0;
			sh_empty_r   <= 1'b1;
			arm_r        <= 1'b0;
			tx_empty_o   <= 1'b0;
			rx_full_o    <= 1'b0;
			complete_o   <= 1'b0;
			overrun_o    <= 1'b0;
			irq_o        <= 1'b0;
		end else begin
			txbuf_full_r <= txbuf_full_nxt;
			sh_empty_r   <= ~enable_i | rx_load | (sh_empty_r & ~load);
			arm_r        <= arm_nxt;
			tx_empty_o   <= emp_nxt;
			rx_full_o    <= enable_i & (rx_load | (rx_full_o & ~rx_rd_i));
			complete_o   <= cmp_nxt;
			overrun_o    <= enable_i & ((ovr_pt & rx_full_o & ~rx_rd_i) |
				(overrun_o & ~rx_rd_i));
			irq_o        <= int_sel_i ? cmp_nxt : (emp_nxt & arm_nxt);
		end
	end

	// ---------------------------------------------------------------
	// Pin drivers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sdo_o      <= MISO_IDLE;
			sdo_oe_n_o <= 1'b1;
			aux_o      <= 1'b0;
			aux_oe_n_o <= 1'b1;
		end else begin
			sdo_oe_n_o <= 1'b0;
			aux_oe_n_o <= slave_i;
			if (slave_i) begin
				sdo_o <= selected ? out_bit(sh_nxt, lsb_first_i) : MISO_IDLE;
				aux_o <= 1'b0;
			end else begin
				sdo_o <= out_bit(sh_nxt, lsb_first_i);
				if (st_nxt != ST_XFER || !master_on)
					aux_o <= cpol_i;
				else if (tick)
					aux_o <= lead ? ~cpol_i : cpol_i;
			end
		end
	end

	spi_tx_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.ref_clk_i   (ref_clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (tx_valid_i),
		.in_ready_o  (tx_ready_o),
		.in_data_i   (tx_data_i),
		.out_valid_o (fifo_valid),
		.out_ready_i (fill),
		.out_data_o  (fifo_data)
	);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_clk_idle_level: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(master_on && st_r == ST_IDLE && $stable(cpol_i)) |=> aux_o == cpol_i)
		else $error("master clock not at idle level");

	a_div_two_tap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(m_tick && clk_sel_i == 3'h0 && $stable(clk_sel_i) && master_on)
		|=> !m_tick ##1 (m_tick || !master_on))
		else $error("divide-by-two tick spacing wrong");

	a_disable_clears: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!enable_i |=> !tx_empty_o && !rx_full_o && !complete_o && !overrun_o && !irq_o)
		else $error("status not reset while disabled");

	a_rx_full_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(rx_load && enable_i) |=> rx_full_o && rx_data_o == $past(rx_byte))
		else $error("receive full not set on eighth bit");

	a_complete_timing: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(rx_load && enable_i) |=> (cpha_i ? complete_o : !$rose(complete_o)))
		else $error("complete not aligned with receive full");

	a_overrun_order: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(overrun_o) |-> rx_full_o && !$past(rx_load))
		else $error("overrun without pending byte");

	a_deselect_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(slave_i && !selected) |=> sdo_o == MISO_IDLE && hc_r == HALF_FIRST)
		else $error("slave not idle while deselected");

	a_aux_tristate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		slave_i |=> aux_oe_n_o)
		else $error("aux driven in slave role");

	a_no_early_irq: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!int_sel_i && !arm_r && !load) |=> !irq_o)
		else $error("empty interrupt before first load");

	a_empty_on_enable: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		($rose(enable_i) && !fifo_valid) |=> tx_empty_o)
		else $error("transmit empty not set on enable");

endmodule

// *** dv/spi_slave_model.sv ***
// Purpose: Behavioural serial slave facing the engine in its master role.
// Assumes: Counters are held clear while the engine is disabled.
// Notes:   A released data line shows the inverse of the last bit sent.

`timescale 1ns/10ps

module spi_slave_model (
	input  wire logic       arst_i, // Hold bit counters clear
	input  wire logic       sclk_i, // Serial clock from master
	input  wire logic       mosi_i, // Data from master
	input  wire logic       cpol_i, // Clock idle level
	input  wire logic       cpha_i, // Clock phase
	input  wire logic       lsb_i,  // Bit order
	input  wire logic [7:0] tx_i,   // Byte returned to master
	output logic            miso_o, // Data to master
	output logic      [7:0] rx_o    // Captured byte
);
	int lead_n = 0;
	int trail_n = 0;
	int k;

	initial rx_o = 8'h00;

	always @(posedge arst_i) begin
		lead_n = 0;
		trail_n = 0;
	end

	// ---------------------------------------------------------------
	// Edge handling
	// ---------------------------------------------------------------
	always @(sclk_i) begin
		if (!arst_i && sclk_i !== cpol_i) begin
			if (!cpha_i) rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
			lead_n++;
		end else if (!arst_i) begin
			if (cpha_i) rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
			trail_n++;
			if (trail_n == 8) begin
				lead_n = 0;
				trail_n = 0;
			end
		end
	end

	// Phase 1 presents on leading edges, phase 0 on trailing ones
	always @* begin
		k = cpha_i ? lead_n - 1 : trail_n;
		if (!arst_i && k >= 0 && k < 8) miso_o = lsb_i ? tx_i[k] : tx_i[7-k];
		else miso_o = ~(lsb_i ? tx_i[7] : tx_i[0]);
	end
endmodule

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the serial master/slave engine.
// Assumes: Inputs change on the falling clock edge only.
// Notes:   Master runs at /8 so a half bit is 8 system clocks.

`timescale 1ns/10ps

module tb_top;
	import spi_engine_pkg::*;

	logic              ref_clk_i, rst_i, enable_i, slave_i, cpha_i, cpol_i, lsb_first_i;
	logic              int_sel_i, ss_en_n_i, ss_fw_n_i, ss_pin_n_i, sclk_i, tb_sdi;
	logic              tx_valid_i, rx_rd_i, cr_rd_i, tx_ready_o, tx_empty_o, rx_full_o;
	logic              complete_o, overrun_o, irq_o, sdo_o, sdo_oe_n_o, aux_o, aux_oe_n_o;
	logic              p_miso;
	logic [SEL_W-1:0]  clk_sel_i;
	logic [DATA_W-1:0] tx_data_i, rx_data_o, p_tx, p_rx, got;
	wire logic         sdi_i;
	int                miscompares = 0;
	int                n_tests = 0;
	int                cyc = 0;
	int                k;

	assign sdi_i = slave_i ? tb_sdi : p_miso;

	spi_master_slave_engine dut_u (.ref_clk_i, .rst_i, .enable_i, .slave_i, .cpha_i, .cpol_i,
		.lsb_first_i, .clk_sel_i, .int_sel_i, .ss_en_n_i, .ss_fw_n_i, .ss_pin_n_i, .sclk_i,
		.sdi_i, .tx_valid_i, .tx_data_i, .tx_ready_o, .rx_rd_i, .cr_rd_i, .rx_data_o,
		.tx_empty_o, .rx_full_o, .complete_o, .overrun_o, .irq_o, .sdo_o, .sdo_oe_n_o,
		.aux_o, .aux_oe_n_o);

	spi_slave_model p_u (.arst_i(!enable_i), .sclk_i(aux_o), .mosi_i(sdo_o), .cpol_i,
		.cpha_i, .lsb_i(lsb_first_i), .tx_i(p_tx), .miso_o(p_miso), .rx_o(p_rx));

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic wrap_up();
		$display("tests=%0d miscompares=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Ceiling well above the roughly 4k cycles the sequence needs
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			wrap_up();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask

	task automatic setup(input logic sl, input logic [1:0] md, input logic lsb, input int c);
		enable_i = 1'b0;
		ticks(2);
		slave_i = sl;
		cpha_i = md[1];
		cpol_i = md[0];
		sclk_i = md[0];
		lsb_first_i = lsb;
		clk_sel_i = c[2:0];
		int_sel_i = 1'b0;
		ticks(2);
		enable_i = 1'b1;
		ticks(3);
	endtask

	// Ready seen at a falling edge is what the next rising edge samples
	task automatic push(input logic [7:0] b);
		while (tx_ready_o !== 1'b1) ticks(1);
		tx_data_i = b;
		tx_valid_i = 1'b1;
		ticks(1);
		tx_valid_i = 1'b0;
		ticks(1);
	endtask

	// Plays the far-side master; the clock stands still between frames
	task automatic drive(input logic [7:0] b, input int nb);
		for (int i = 0; i < nb; i++) begin
			if (!cpha_i) tb_sdi = lsb_first_i ? b[i] : b[7-i];
			ticks(16);
			sclk_i = ~cpol_i;
			if (cpha_i) tb_sdi = lsb_first_i ? b[i] : b[7-i];
			else got = lsb_first_i ? {sdo_o, got[7:1]} : {got[6:0], sdo_o};
			ticks(16);
			sclk_i = cpol_i;
			if (cpha_i) got = lsb_first_i ? {sdo_o, got[7:1]} : {got[6:0], sdo_o};
		end
		ticks(16);
		tb_sdi = ~tb_sdi;
	endtask

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial begin
		{rst_i, ss_en_n_i, ss_fw_n_i, ss_pin_n_i} = 4'hf;
		{enable_i, slave_i, cpha_i, cpol_i, lsb_first_i, int_sel_i, sclk_i, tb_sdi} = 8'h00;
		{tx_valid_i, rx_rd_i, cr_rd_i, clk_sel_i, tx_data_i, p_tx, got} = 30'h0;
		ticks(3);
		rst_i = 1'b0;
		ticks(2);
		chk(tx_empty_o, 0);
		for (int m = 0; m < 4; m++) begin
			p_tx = 8'h5a ^ m[7:0];
			setup(1'b0, m[1:0], m[1] ^ m[0], 2);
			chk(aux_o, cpol_i);
			chk(tx_empty_o, 1);
			chk(irq_o, 0);
			chk({sdo_oe_n_o, aux_oe_n_o, tx_ready_o}, 3'b001);
			push(8'h96 ^ m[7:0]);
			for (k = 0; k < 600 && rx_full_o !== 1'b1; k++) ticks(1);
			for (k = 0; k < 20 && complete_o !== 1'b1; k++) ticks(1);
			chk(k, cpha_i ? 0 : 8);
			chk(rx_data_o, 8'h5a ^ m[7:0]);
			chk(p_rx, 8'h96 ^ m[7:0]);
			chk(irq_o, 1);
			chk(aux_o, cpol_i);
			int_sel_i = 1'b1;
			ticks(2);
			chk(irq_o, 1);
			cr_rd_i = 1'b1;
			ticks(1);
			cr_rd_i = 1'b0;
			ticks(1);
			chk({complete_o, irq_o}, 0);
			rx_rd_i = 1'b1;
			ticks(1);
			rx_rd_i = 1'b0;
			ticks(1);
			chk(rx_full_o, 0);
		end
		p_tx = 8'hc3;
		setup(1'b0, 2'b00, 1'b0, 2);
		push(8'h11);
		push(8'h22);
		for (k = 0; k < 600 && complete_o !== 1'b1; k++) ticks(1);
		for (k = 0; k < 140 && overrun_o !== 1'b1; k++) ticks(1);
		chk(overrun_o, 1);
		ticks(20);
		chk(p_rx, 8'h22);
		enable_i = 1'b0;
		ticks(2);
		chk({overrun_o, rx_full_o, complete_o, tx_empty_o}, 0);
		chk({aux_o, rx_data_o}, {1'b0, 8'hc3});
		for (int c = 0; c < 8; c++) begin
			setup(1'b0, 2'b00, 1'b0, c);
			push(8'h00);
			for (k = 0; k < 600 && aux_o !== 1'b1; k++) ticks(1);
			for (k = 0; k < 600 && aux_o !== 1'b0; k++) ticks(1);
			chk(k, 2 << c);
		end
		for (int m = 0; m < 4; m++) begin
			setup(1'b1, m[1:0], m[0], 0);
			ss_en_n_i = ~m[0];
			push(8'h3c ^ m[7:0]);
			ticks(4);
			chk({sdo_o, aux_oe_n_o}, 2'b11);
			if (m[0]) ss_fw_n_i = 1'b0;
			else ss_pin_n_i = 1'b0;
			drive(8'ha5 ^ m[7:0], 8);
			{ss_fw_n_i, ss_pin_n_i} = 2'b11;
			ticks(6);
			chk(rx_data_o, 8'ha5 ^ m[7:0]);
			chk(got, 8'h3c ^ m[7:0]);
			chk({rx_full_o, sdo_o}, 2'b11);
		end
		setup(1'b1, 2'b00, 1'b0, 0);
		ss_en_n_i = 1'b1;
		ss_pin_n_i = 1'b0;
		drive(8'hff, 4);
		ss_pin_n_i = 1'b1;
		ticks(4);
		chk(sdo_o, 1);
		drive(8'hff, 8);
		chk(rx_full_o, 0);
		ss_pin_n_i = 1'b0;
		drive(8'h5c, 8);
		ticks(4);
		chk(rx_data_o, 8'h5c);
		enable_i = 1'b0;
		ticks(2);
		chk({sdo_o, rx_full_o}, 2'b10);
		wrap_up();
	end
endmodule
